/* annp_regs.sv */
// annp_regs: expansion, next-page transmit and partner next-page registers
// assumes the negotiation engine and management port share clk_i
//
// How it works
// (R1) the parallel-detection fault flag latches high on a fault and stays set until cleared, reading 0 after reset.
// (R2) the partner next-page ability bit mirrors the engine's indication, read-only, 0 at reset.
// (R3) the local next-page capability bit always reads 1, read-only.
// (R4) the page-received flag latches high on each new partner page and reads 0 otherwise, 0 at reset.
// (R5) the partner autonegotiation ability bit mirrors the engine's indication, read-only, 0 at reset.
// (R6) software writes the more-pages bit of the transmit page, which resets to 0.
// (R7) the transmit page format bit is writable and resets to 1, while bit 14 reads 0.
// (R8) the transmit comply bit is writable and resets to 0.
// (R9) the transmit toggle bit is read-only, flips after each page sent and resets to 0.
// (R10) the transmit message code field is writable and resets to 1.
// (R11) the partner more-pages bit is read-only, loaded from each received page, 0 at reset.
// (R12) the partner acknowledge bit is read-only, loaded from each received page, 0 at reset.
// (R13) the partner format and comply bits are loaded from received pages, writable, 0 at reset.
// (R14) the partner toggle is read-only and its code field is loaded from received pages and writable, 0 at reset.
// (R15) expansion bits 15 to 5 read as 0 and ignore writes.
// (R16) latching-high flags clear when the expansion register is read unless the event recurs.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module annp_regs
    import annp_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    // management register port
    input  wire logic [ANNP_ADDR_W-1:0] addr_i,
    input  wire logic [ANNP_DATA_W-1:0] wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [ANNP_DATA_W-1:0] rdata_o,
    // negotiation engine status
    input  wire logic                   par_fault_i,
    input  wire logic                   lp_np_able_i,
    input  wire logic                   lp_an_able_i,
    // received and transmitted pages
    input  wire logic                   page_rx_i,
    input  wire logic [ANNP_DATA_W-1:0] rx_page_i,
    input  wire logic                   tx_sent_i,
    output logic      [ANNP_DATA_W-1:0] tx_page_o,
    // interrupt
    output logic                        irq_o
);

    // address match used by every decode
    function automatic logic addr_hit(
        input logic [ANNP_ADDR_W-1:0] addr,
        input logic [ANNP_ADDR_W-1:0] off
    );
        addr_hit = (addr == off);
    endfunction : addr_hit

    // latching-high flags
    logic fault_q;
    logic fault_d;
    logic page_q;
    logic page_d;

    // transmit page fields
    logic                   tx_more_q;
    logic                   tx_fmt_q;
    logic                   tx_ack2_q;
    logic                   toggle_q;
    logic [ANNP_CODE_W-1:0] tx_code_q;

    // partner page and read data
    logic [ANNP_DATA_W-1:0] lp_q;
    logic [ANNP_DATA_W-1:0] lp_d;
    logic [ANNP_DATA_W-1:0] rdata_q;

    // decode wires
    logic                   exp_rd;
    logic                   tx_wr;
    logic                   lp_wr;
    logic                   st_wr;
    logic                   mk_wr;
    logic [ANNP_DATA_W-1:0] exp_val;
    logic [ANNP_DATA_W-1:0] tx_val;
    logic [ANNP_DATA_W-1:0] irq_st_val;
    logic [ANNP_DATA_W-1:0] irq_mk_val;
    logic [ANNP_DATA_W-1:0] rd_mux;
    logic [ANNP_DATA_W-1:0] lp_wmask;

    annp_irq_if irq_bus ();

    // access decode
    assign exp_rd = rd_i && addr_hit(addr_i, ANNP_OFF_EXP);
    assign tx_wr  = wr_i && addr_hit(addr_i, ANNP_OFF_TXNP);
    assign lp_wr  = wr_i && addr_hit(addr_i, ANNP_OFF_LPNP);
    assign st_wr  = wr_i && addr_hit(addr_i, ANNP_OFF_IRQ_ST);
    assign mk_wr  = wr_i && addr_hit(addr_i, ANNP_OFF_IRQ_MK);

    // latching flags: a new event outranks the read that clears
    assign fault_d = par_fault_i | (fault_q & ~exp_rd); // R1 R16
    assign page_d  = page_rx_i | (page_q & ~exp_rd);    // R4 R16

    // flag flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_q <= 1'b0;
            page_q  <= 1'b0;
        end else begin
            fault_q <= fault_d; // R1
            page_q  <= page_d;  // R4
        end
    end

    // expansion register image, upper bits reserved
    assign exp_val = {
        {(ANNP_DATA_W-EXP_RSV_LO_B){1'b0}}, // R15
        fault_q,                            // R1
        lp_np_able_i,                       // R2
        RST_LOC_NP,                         // R3
        page_q,                             // R4
        lp_an_able_i                        // R5
    };

    // transmit page writable fields
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_more_q <= RST_TX_MORE;
            tx_fmt_q  <= RST_TX_FMT;
            tx_ack2_q <= RST_TX_ACK2;
            tx_code_q <= RST_TX_CODE;
        end else if (tx_wr) begin
            tx_more_q <= wdata_i[NP_MORE_B];              // R6
            tx_fmt_q  <= wdata_i[NP_FMT_B];               // R7
            tx_ack2_q <= wdata_i[NP_ACK2_B];              // R8
            tx_code_q <= wdata_i[NP_CODE_HI:0];           // R10
        end
    end

    // toggle flips once each time the engine sends a page
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            toggle_q <= RST_TOGGLE;
        end else if (tx_sent_i) begin
            toggle_q <= ~toggle_q; // R9
        end
    end

    // transmit page image, bit 14 reserved as zero
    assign tx_val = {tx_more_q, 1'b0, tx_fmt_q, tx_ack2_q, // R7
                     toggle_q, tx_code_q};

    // partner page: received page wins over a software write
    assign lp_wmask = (16'h1 << NP_FMT_B) | (16'h1 << NP_ACK2_B)
                    | 16'h07FF;
    assign lp_d = page_rx_i ? rx_page_i                    // R11 R12 R14
                : lp_wr     ? ((lp_q & ~lp_wmask)
                               | (wdata_i & lp_wmask))      // R13
                : lp_q;

    // partner page flop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lp_q <= RST_LPNP; // R11 R12 R13 R14
        end else begin
            lp_q <= lp_d;
        end
    end

    // interrupt unit hookup
    assign irq_bus.event_set = {tx_sent_i, par_fault_i, page_rx_i};
    assign irq_bus.sts_wr    = st_wr;
    assign irq_bus.msk_wr    = mk_wr;
    assign irq_bus.wdata     = wdata_i[ANNP_IRQ_W-1:0];

    annp_irq_ctrl u_irq (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .bus     (irq_bus.ctrl)
    );

    assign irq_st_val = {{(ANNP_DATA_W-ANNP_IRQ_W){1'b0}}, irq_bus.status};
    assign irq_mk_val = {{(ANNP_DATA_W-ANNP_IRQ_W){1'b0}}, irq_bus.mask};

    // read selection, unmapped addresses read zero
    assign rd_mux =
        addr_hit(addr_i, ANNP_OFF_EXP)    ? exp_val    :
        addr_hit(addr_i, ANNP_OFF_TXNP)   ? tx_val     :
        addr_hit(addr_i, ANNP_OFF_LPNP)   ? lp_q       :
        addr_hit(addr_i, ANNP_OFF_IRQ_ST) ? irq_st_val :
        addr_hit(addr_i, ANNP_OFF_IRQ_MK) ? irq_mk_val :
        RST_RDATA;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= RST_RDATA;
        end else begin
            rdata_q <= rd_i ? rd_mux : RST_RDATA;
        end
    end

    // outputs straight from flops
    assign rdata_o   = rdata_q;
    assign tx_page_o = tx_val;
    assign irq_o     = irq_bus.irq;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence exp_read_s;
        rd_i && (addr_i == ANNP_OFF_EXP);
    endsequence

    sequence tx_write_s;
        wr_i && (addr_i == ANNP_OFF_TXNP);
    endsequence

    // fault flag sets on the event and holds until a read
    fault_set_a: assert property ( // R1
        par_fault_i |=> fault_q
    ) else $error("fault flag not latched");

    fault_hold_a: assert property ( // R1
        (fault_q && !exp_rd) |=> fault_q
    ) else $error("fault flag dropped without a read");

    // read data shows live partner abilities
    lp_np_read_a: assert property ( // R2
        exp_read_s |=> rdata_o[EXP_LP_NP_B] == $past(lp_np_able_i)
    ) else $error("partner next-page ability misreported");

    loc_np_read_a: assert property ( // R3
        exp_read_s |=> rdata_o[EXP_LOC_NP_B]
    ) else $error("local next-page capability not read as one");

    page_set_a: assert property ( // R4
        page_rx_i ##1 (!exp_rd)[*2] |=> page_q
    ) else $error("page received flag lost");

    lp_an_read_a: assert property ( // R5
        exp_read_s |=> rdata_o[EXP_LP_AN_B] == $past(lp_an_able_i)
    ) else $error("partner negotiation ability misreported");

    // write to transmit page lands in the outgoing word
    tx_write_a: assert property ( // R6
        tx_write_s |=> (tx_page_o[NP_MORE_B] == $past(wdata_i[NP_MORE_B]))
            && (tx_page_o[NP_FMT_B] == $past(wdata_i[NP_FMT_B]))
            && (tx_page_o[NP_ACK2_B] == $past(wdata_i[NP_ACK2_B]))
            && (tx_page_o[NP_CODE_HI:0] == $past(wdata_i[NP_CODE_HI:0]))
    ) else $error("transmit page write not applied");

    tx_rsv_a: assert property ( // R7
        !tx_page_o[NP_ACK_B]
    ) else $error("transmit reserved bit set");

    toggle_flip_a: assert property ( // R9
        tx_sent_i |=> toggle_q != $past(toggle_q)
    ) else $error("toggle did not flip after a sent page");

    toggle_still_a: assert property ( // R9
        !tx_sent_i |=> $stable(toggle_q)
    ) else $error("toggle moved without a sent page");

    lp_capture_a: assert property ( // R11
        page_rx_i |=> lp_q == $past(rx_page_i)
    ) else $error("partner page not captured");

    exp_rsv_a: assert property ( // R15
        exp_read_s |=> rdata_o[ANNP_DATA_W-1:EXP_RSV_LO_B] == '0
    ) else $error("expansion reserved bits not zero");

    latch_clear_a: assert property ( // R16
        (exp_read_s and (!par_fault_i && !page_rx_i)) |=> !fault_q && !page_q
    ) else $error("latched flags survived a read");

    rd_idle_a: assert property (
        !rd_i |=> rdata_o == '0
    ) else $error("read data outside its slot");

endmodule : annp_regs

/* annp_pkg.sv */
// annp_pkg: constants for the autonegotiation next-page register bank
// assumes 16-bit management registers reached at 5-bit register addresses
package annp_pkg;

    // register port widths
    localparam int unsigned ANNP_ADDR_W = 5;
    localparam int unsigned ANNP_DATA_W = 16;
    localparam int unsigned ANNP_CODE_W = 11;
    localparam int unsigned ANNP_IRQ_W  = 3;

    // register addresses
    localparam logic [4:0] ANNP_OFF_EXP    = 5'h06;
    localparam logic [4:0] ANNP_OFF_TXNP   = 5'h07;
    localparam logic [4:0] ANNP_OFF_LPNP   = 5'h08;
    localparam logic [4:0] ANNP_OFF_IRQ_ST = 5'h10;
    localparam logic [4:0] ANNP_OFF_IRQ_MK = 5'h11;

    // expansion register fields
    localparam int unsigned EXP_FAULT_B   = 4;
    localparam int unsigned EXP_LP_NP_B   = 3;
    localparam int unsigned EXP_LOC_NP_B  = 2;
    localparam int unsigned EXP_PAGE_B    = 1;
    localparam int unsigned EXP_LP_AN_B   = 0;
    localparam int unsigned EXP_RSV_LO_B  = 5;

    // next-page word fields, shared by transmit and partner registers
    localparam int unsigned NP_MORE_B   = 15;
    localparam int unsigned NP_ACK_B    = 14;
    localparam int unsigned NP_FMT_B    = 13;
    localparam int unsigned NP_ACK2_B   = 12;
    localparam int unsigned NP_TOGGLE_B = 11;
    localparam int unsigned NP_CODE_HI  = 10;

    // reset values
    localparam logic        RST_LOC_NP  = 1'b1;
    localparam logic        RST_TX_MORE = 1'b0;
    localparam logic        RST_TX_FMT  = 1'b1;
    localparam logic        RST_TX_ACK2 = 1'b0;
    localparam logic        RST_TOGGLE  = 1'b0;
    localparam logic [10:0] RST_TX_CODE = 11'h001;
    localparam logic [15:0] RST_LPNP    = 16'h0000;
    localparam logic [15:0] RST_RDATA   = 16'h0000;

    // interrupt status and mask bit positions
    localparam int unsigned IRQ_PAGE_B  = 0;
    localparam int unsigned IRQ_FAULT_B = 1;
    localparam int unsigned IRQ_SENT_B  = 2;
    localparam logic [2:0]  RST_IRQ     = 3'h0;

endpackage : annp_pkg

/* annp_irq_if.sv */
// annp_irq_if: event and register path between the bank and its irq unit
// assumes both ends run on the same clock and reset
`timescale 1ns/100ps
interface annp_irq_if;
    import annp_pkg::*;

    logic [ANNP_IRQ_W-1:0] event_set;  // one-cycle event pulses
    logic                  sts_wr;     // write-one-to-clear strobe
    logic                  msk_wr;     // mask write strobe
    logic [ANNP_IRQ_W-1:0] wdata;      // write data for either strobe
    logic [ANNP_IRQ_W-1:0] status;     // sticky status readback
    logic [ANNP_IRQ_W-1:0] mask;       // mask readback
    logic                  irq;        // registered interrupt level

    modport core (
        output event_set, sts_wr, msk_wr, wdata,
        input  status, mask, irq
    );
    modport ctrl (
        input  event_set, sts_wr, msk_wr, wdata,
        output status, mask, irq
    );
endinterface : annp_irq_if

/* annp_irq_ctrl.sv */
// annp_irq_ctrl: sticky event status, mask and one level interrupt
// assumes strobes come from logic on the same clock
`timescale 1ns/100ps
module annp_irq_ctrl
    import annp_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // register side
    annp_irq_if.ctrl  bus
);

    logic [ANNP_IRQ_W-1:0] status_q;
    logic [ANNP_IRQ_W-1:0] status_d;
    logic [ANNP_IRQ_W-1:0] mask_q;
    logic [ANNP_IRQ_W-1:0] mask_d;
    logic [ANNP_IRQ_W-1:0] clr_bits;
    logic                  irq_q;

    // a new event wins over a clear in the same cycle
    assign clr_bits = bus.sts_wr ? bus.wdata : RST_IRQ;
    assign status_d = bus.event_set | (status_q & ~clr_bits);
    assign mask_d   = bus.msk_wr ? bus.wdata : mask_q;

    // status, mask and interrupt flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_q <= RST_IRQ;
            mask_q   <= RST_IRQ;
            irq_q    <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q   <= mask_d;
            irq_q    <= |(status_d & mask_d);
        end
    end

    assign bus.status = status_q;
    assign bus.mask   = mask_q;
    assign bus.irq    = irq_q;

endmodule : annp_irq_ctrl

/* annp_engine_model.sv */
// annp_engine_model: negotiation engine stand-in beside the register bank
// assumes the bench calls its tasks from the clk_i domain
`timescale 1ns/100ps
module annp_engine_model
    import annp_pkg::*;
(
    // clock
    input  wire logic                   clk_i,
    // engine indications toward the bank
    output logic                        par_fault_o,
    output logic                        lp_np_able_o,
    output logic                        lp_an_able_o,
    // received and transmitted pages
    output logic                        page_rx_o,
    output logic      [ANNP_DATA_W-1:0] rx_page_o,
    output logic                        tx_sent_o
);
    // idle levels; the page word carries junk while not valid
    initial begin
        par_fault_o  = 1'b0;
        lp_np_able_o = 1'b0;
        lp_an_able_o = 1'b0;
        page_rx_o    = 1'b0;
        rx_page_o    = 16'h5a5a;
        tx_sent_o    = 1'b0;
    end

    // one received page, word valid only beside its strobe
    task automatic send_page(input logic [ANNP_DATA_W-1:0] w);
        @(posedge clk_i);
        page_rx_o <= 1'b1;
        rx_page_o <= w;
        @(posedge clk_i);
        page_rx_o <= 1'b0;
        rx_page_o <= ~w; // stale word must not be relied on
    endtask : send_page

    // one-cycle parallel-detection fault
    task automatic pulse_fault;
        @(posedge clk_i);
        par_fault_o <= 1'b1;
        @(posedge clk_i);
        par_fault_o <= 1'b0;
    endtask : pulse_fault

    // current next page has gone out on the wire
    task automatic pulse_sent;
        @(posedge clk_i);
        tx_sent_o <= 1'b1;
        @(posedge clk_i);
        tx_sent_o <= 1'b0;
    endtask : pulse_sent

    // partner abilities as levels
    task automatic set_ability(input logic np, input logic an);
        @(posedge clk_i);
        lp_np_able_o <= np;
        lp_an_able_o <= an;
    endtask : set_ability
endmodule : annp_engine_model

/* annp_regs_tb.sv */
// annp_regs_tb: self-checking bench for the next-page register bank
// assumes the engine model drives the engine inputs on the same clock
`timescale 1ns/100ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
    n_errors++; $display("ERROR %0t got %h exp %h", $time, got, exp); \
    end end
module annp_regs_tb;
    import annp_pkg::*;
    logic                   clk_i;
    logic                   rst_n_i;
    logic [ANNP_ADDR_W-1:0] addr_i;
    logic [ANNP_DATA_W-1:0] wdata_i;
    logic                   wr_i;
    logic                   rd_i;
    logic [ANNP_DATA_W-1:0] rdata_o;
    logic                   par_fault_i;
    logic                   lp_np_able_i;
    logic                   lp_an_able_i;
    logic                   page_rx_i;
    logic [ANNP_DATA_W-1:0] rx_page_i;
    logic                   tx_sent_i;
    logic [ANNP_DATA_W-1:0] tx_page_o;
    logic                   irq_o;
    int                     n_errors = 0;
    int                     num_checks = 0;

    // device under test and its engine
    annp_regs uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .par_fault_i(par_fault_i), .lp_np_able_i(lp_np_able_i),
        .lp_an_able_i(lp_an_able_i), .page_rx_i(page_rx_i),
        .rx_page_i(rx_page_i), .tx_sent_i(tx_sent_i),
        .tx_page_o(tx_page_o), .irq_o(irq_o));
    annp_engine_model u_eng (.clk_i(clk_i), .par_fault_o(par_fault_i),
        .lp_np_able_o(lp_np_able_i), .lp_an_able_o(lp_an_able_i),
        .page_rx_o(page_rx_i), .rx_page_o(rx_page_i),
        .tx_sent_o(tx_sent_i));

    // 20 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // one-cycle write strobe
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] w);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= w;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr_reg

    // one-cycle read strobe, data judged in the following cycle
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        `CHK(rdata_o, e)
    endtask : rd_chk

    // print counts and verdict, then stop
    task automatic close_out;
        $display("n_errors=%0d num_checks=%0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // reset values of the expansion and both next-page registers and the outputs
    task automatic t_reset;
        rd_chk(ANNP_OFF_EXP, 16'h0004);
        rd_chk(ANNP_OFF_TXNP, 16'h2001);
        rd_chk(ANNP_OFF_LPNP, 16'h0000);
        `CHK(tx_page_o, 16'h2001)
        `CHK(irq_o, 1'b0)
    endtask : t_reset

    // live partner abilities; read data stands one cycle only
    task automatic t_live;
        u_eng.set_ability(1'b1, 1'b1);
        rd_chk(ANNP_OFF_EXP, 16'h000d);
        @(posedge clk_i);
        #1;
        `CHK(rdata_o, 16'h0000)
        u_eng.set_ability(1'b0, 1'b0);
    endtask : t_live

    // writable transmit fields, reserved and toggle bits held
    task automatic t_txnp;
        wr_reg(ANNP_OFF_TXNP, 16'hffff);
        `CHK(tx_page_o, 16'hb7ff)
        rd_chk(ANNP_OFF_TXNP, 16'hb7ff);
        wr_reg(ANNP_OFF_TXNP, 16'h0000);
        rd_chk(ANNP_OFF_TXNP, 16'h0000);
    endtask : t_txnp

    // toggle flips per page sent and ignores writes
    task automatic t_toggle;
        u_eng.pulse_sent();
        #1;
        `CHK(tx_page_o, 16'h0800)
        wr_reg(ANNP_OFF_TXNP, 16'h0000);
        rd_chk(ANNP_OFF_TXNP, 16'h0800);
        u_eng.pulse_sent();
        #1;
        `CHK(tx_page_o, 16'h0000)
    endtask : t_toggle

    // partner page capture, latched flag, software write of partner page
    task automatic t_page;
        u_eng.send_page(16'hffff);
        rd_chk(ANNP_OFF_LPNP, 16'hffff);
        rd_chk(ANNP_OFF_EXP, 16'h0006);
        rd_chk(ANNP_OFF_EXP, 16'h0004);
        wr_reg(ANNP_OFF_LPNP, 16'h0000);
        rd_chk(ANNP_OFF_LPNP, 16'hc800);
        u_eng.send_page(16'h2abc);
        rd_chk(ANNP_OFF_LPNP, 16'h2abc);
        rd_chk(ANNP_OFF_EXP, 16'h0006);
        // a page arriving beside the clearing read still sets the flag
        fork
            rd_chk(ANNP_OFF_EXP, 16'h0004);
            u_eng.send_page(16'h0155);
        join
        rd_chk(ANNP_OFF_EXP, 16'h0006);
    endtask : t_page

    // fault latch, read-only expansion register
    task automatic t_fault;
        u_eng.pulse_fault();
        wr_reg(ANNP_OFF_EXP, 16'hffff);
        rd_chk(ANNP_OFF_EXP, 16'h0014);
        rd_chk(ANNP_OFF_EXP, 16'h0004);
    endtask : t_fault

    // interrupt raise, clear, mask and an unmapped address
    task automatic t_irq;
        // page, fault and sent events from earlier scenarios all stuck
        rd_chk(ANNP_OFF_IRQ_ST, 16'h0007);
        wr_reg(ANNP_OFF_IRQ_ST, 16'h0007);
        wr_reg(ANNP_OFF_IRQ_MK, 16'h0007);
        rd_chk(ANNP_OFF_IRQ_MK, 16'h0007);
        u_eng.send_page(16'h0123);
        @(posedge clk_i);
        #1;
        `CHK(irq_o, 1'b1)
        rd_chk(ANNP_OFF_IRQ_ST, 16'h0001);
        wr_reg(ANNP_OFF_IRQ_ST, 16'h0001);
        @(posedge clk_i);
        #1;
        `CHK(irq_o, 1'b0)
        rd_chk(ANNP_OFF_IRQ_ST, 16'h0000);
        wr_reg(ANNP_OFF_IRQ_MK, 16'h0000);
        u_eng.pulse_fault();
        @(posedge clk_i);
        #1;
        `CHK(irq_o, 1'b0)
        rd_chk(ANNP_OFF_IRQ_ST, 16'h0002);
        rd_chk(5'h1f, 16'h0000);
    endtask : t_irq

    // main sequence
    initial begin
        rst_n_i = 1'b0;
        addr_i  = '0;
        wdata_i = '0;
        wr_i    = 1'b0;
        rd_i    = 1'b0;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_live();
        t_txnp();
        t_toggle();
        t_page();
        t_fault();
        t_irq();
        close_out();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        close_out();
    end
endmodule : annp_regs_tb
